// file: src/tcc_control.sv
/*
 * Receive buffer FIFO and the command, filter and status logic of the transparent receive path.
 * Assumes the host command port, the CAN controller and the frame source share i_clk.
 */
`timescale 1ns/1ps

module tcc_fifo #(
	parameter int W     = 80,
	parameter int DEPTH = 255,
	parameter int CW    = 8
) (
	// Clock and reset.
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	// Fill side.
	input  wire logic          i_in_valid,
	output logic               o_in_ready,
	input  wire logic [W-1:0]  i_in_data,
	// Drain side.
	output logic               o_out_valid,
	input  wire logic          i_out_ready,
	output logic [W-1:0]       o_out_data,
	// Control and level.
	input  wire logic          i_flush,
	output logic [CW-1:0]      o_count
);
	localparam logic [CW-1:0] LAST  = CW'(DEPTH - 1);
	localparam logic [CW-1:0] FULLC = CW'(DEPTH);
	localparam logic [CW-1:0] ONE   = CW'(1);
	localparam logic [CW-1:0] ZERO  = CW'(0);

	logic [W-1:0]  mem_ff [DEPTH];
	logic [CW-1:0] wr_ptr_ff;
	logic [CW-1:0] rd_ptr_ff;
	logic [CW-1:0] count_ff;

	wire push = i_in_valid && o_in_ready && !i_flush;
	wire pop  = o_out_valid && i_out_ready && !i_flush;
	wire [CW-1:0] nxt_wr_ptr = (wr_ptr_ff == LAST) ? ZERO : wr_ptr_ff + ONE;
	wire [CW-1:0] nxt_rd_ptr = (rd_ptr_ff == LAST) ? ZERO : rd_ptr_ff + ONE;

	assign o_in_ready  = (count_ff != FULLC);
	assign o_out_valid = (count_ff != ZERO);
	assign o_out_data  = mem_ff[rd_ptr_ff];
	assign o_count     = count_ff;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= i_in_data;
		end
	end

	// Count and pointers clear together on a flush, so no stale level is ever shown.
	always_ff @(posedge i_clk) begin
		if (i_rst || i_flush) begin
			wr_ptr_ff <= ZERO;
			rd_ptr_ff <= ZERO;
			count_ff  <= ZERO;
		end else begin
			if (push) begin
				wr_ptr_ff <= nxt_wr_ptr;
			end
			if (pop) begin
				rd_ptr_ff <= nxt_rd_ptr;
			end
			if (push && !pop) begin
				count_ff <= count_ff + ONE;
			end else if (pop && !push) begin
				count_ff <= count_ff - ONE;
			end
		end
	end
endmodule

module tcc_control (
	// Clock and reset.
	input  wire logic                        i_clk,
	input  wire logic                        i_rst,
	// Host command request.
	input  wire logic                        i_req,
	input  wire logic [tcc_pkg::FC_W-1:0]    i_function_code,
	input  wire logic [tcc_pkg::CNT_W-1:0]   i_entry_count,
	output logic                             o_busy,
	output logic [tcc_pkg::RES_W-1:0]        o_result_code,
	// Argument block stream.
	input  wire logic                        i_arg_valid,
	input  wire logic [tcc_pkg::ARG_W-1:0]   i_arg_word,
	output logic                             o_arg_ready,
	// Frames from the CAN controller.
	input  wire logic                        i_rx_valid,
	input  wire tcc_pkg::tcc_frame_t         i_rx_frame,
	output logic                             o_rx_ready,
	// Frame presented to the host.
	output logic                             o_new,
	output tcc_pkg::tcc_frame_t              o_frame,
	input  wire logic                        i_ack,
	// Controller condition and control.
	input  wire logic                        i_bus_off,
	input  wire logic                        i_err_warn,
	output logic                             o_ctrl_halt,
	output logic                             o_protocol_en,
	output logic                             o_listen,
	// Status and diagnosis.
	input  wire logic                        i_diag_en,
	output logic [tcc_pkg::ST_W-1:0]         o_status,
	output logic                             o_ext_error
);
	import tcc_pkg::*;

	tcc_state_t           state_ff;
	tcc_state_t           nxt_state;
	logic                 req_prev_ff;
	logic                 busy_ff;
	logic [RES_W-1:0]     result_ff;
	logic [RES_W-1:0]     nxt_result;
	logic [FC_W-1:0]      fc_ff;
	logic                 zero_cnt_ff;
	logic [CNT_W-1:0]     remain_ff;
	logic                 arg_ready_ff;
	logic                 transp_ff;
	logic                 prot_en_ff;
	logic                 bus_off_ff;
	logic [BUF_CW-1:0]    thr_ff;
	logic [N_ID-1:0]      filter_ff;
	logic                 rx_ready_ff;
	logic                 new_ff;
	tcc_frame_t           frame_ff;
	logic [ST_W-1:0]      status_ff;
	logic                 ext_err_ff;
	logic                 listen_ff;

	// Request decode.
	wire take       = i_req && !req_prev_ff && (state_ff == ST_IDLE); // R16
	wire fc_transp  = (i_function_code == FC_TRANSPARENT);
	wire fc_filter  = (i_function_code == FC_FILTER);
	wire fc_thr     = (i_function_code == FC_THRESHOLD);
	wire fc_flush   = (i_function_code == FC_FLUSH);
	wire fc_resv    = (i_function_code == FC_RESERVED);
	wire fc_clr_bo  = (i_function_code == FC_CLR_BUS_OFF);
	wire allowed    = fc_transp || transp_ff; // R3
	wire go_transp  = take && fc_transp; // R1 R2
	wire go_fetch   = take && allowed && (fc_filter || fc_thr);
	wire go_flush   = take && allowed && fc_flush; // R13
	wire go_clr_bo  = take && allowed && fc_clr_bo; // R14
	wire [CNT_W-1:0] load_remain = (fc_filter && i_entry_count != CNT_ZERO) ?
		i_entry_count : CNT_ONE; // R6

	// Argument word decode.
	wire arg_take   = arg_ready_ff && i_arg_valid;
	wire last_arg   = arg_take && (remain_ff == CNT_ONE);
	wire is_filt    = (fc_ff == FC_FILTER);
	wire all_off    = arg_take && is_filt && zero_cnt_ff && (i_arg_word == ENT_ALL_OFF); // R8
	wire all_on     = arg_take && is_filt && !zero_cnt_ff && (i_arg_word == ENT_ALL_ON); // R10
	wire id_in_rng  = (i_arg_word[ENT_ID_HI:ID_W] == '0);
	wire one_wr     = arg_take && is_filt && !zero_cnt_ff && !all_on && id_in_rng; // R9 R11
	wire [ID_W-1:0] wr_id = i_arg_word[ID_W-1:0];
	wire wr_en_val  = i_arg_word[ENT_EN_BIT]; // R7
	wire thr_ok     = (i_arg_word[ARG_W-1:BUF_CW] == '0) &&
		(i_arg_word[BUF_CW-1:0] >= THR_MIN);
	wire thr_wr     = arg_take && !is_filt && thr_ok; // R12

	// Receive path decode.
	wire          any_en   = |filter_ff;
	wire          accept   = filter_ff[i_rx_frame.id]; // R4
	wire          path_on  = transp_ff && !bus_off_ff && any_en; // R14
	wire          fifo_in_ready;
	wire          fifo_out_valid;
	tcc_frame_t   fifo_out;
	wire [BUF_CW-1:0] fifo_count;
	wire          rx_push  = i_rx_valid && path_on && accept;
	wire          out_ready = !new_ff || i_ack;
	// A flush also drops the head frame, so it must not reach the host in that cycle.
	wire          pop      = fifo_out_valid && out_ready && !go_flush; // R13

	// Status word; undefined bits stay zero and only bus-off is sticky.
	wire st_thr_hit = (fifo_count >= thr_ff); // R12
	wire st_half    = (fifo_count >= BUF_HALF_CNT); // R21
	wire st_full    = (fifo_count == BUF_FULL_CNT); // R20
	wire [ST_W-1:0] nxt_status = {
		{(ST_W - ST_THR_HIT - 1){1'b0}},
		st_thr_hit,
		st_half,
		st_full,
		i_err_warn,
		bus_off_ff
	}; // R12 R17 R18 R19 R20 R21 R24

	tcc_fifo #(
		.W     (FRAME_W),
		.DEPTH (BUF_DEPTH),
		.CW    (BUF_CW)
	) u_rx_buf (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_in_valid  (rx_push),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (i_rx_frame),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (out_ready),
		.o_out_data  (fifo_out),
		.i_flush     (go_flush),
		.o_count     (fifo_count)
	); // R23

	// Acceptance filter, one enable flag per identifier.
	genvar gi;
	generate
		for (gi = 0; gi < N_ID; gi++) begin : g_filt
			wire hit = one_wr && (wr_id == ID_W'(gi));
			always_ff @(posedge i_clk) begin
				if (i_rst || all_off) begin
					filter_ff[gi] <= 1'b0;
				end else if (all_on) begin
					filter_ff[gi] <= 1'b1;
				end else if (hit) begin
					filter_ff[gi] <= wr_en_val; // R5
				end
			end
		end
	endgenerate

	// Command sequencer.
	always_comb begin
		nxt_state  = state_ff;
		nxt_result = result_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (take) begin
					nxt_state = ST_DONE;
					if (!allowed) begin
						nxt_result = RC_NOT_TRANSP;
					end else if (fc_resv) begin
						nxt_result = RC_RESERVED; // R24
					end else if (fc_transp || fc_flush || fc_clr_bo) begin
						nxt_result = RC_OK;
					end else if (go_fetch) begin
						nxt_result = RC_OK;
						nxt_state  = ST_FETCH;
					end else begin
						nxt_result = RC_UNKNOWN_FC;
					end
				end
			end
			ST_FETCH: begin
				if (arg_take && !is_filt && !thr_ok) begin
					nxt_result = RC_BAD_ARG;
				end
				if (last_arg) begin
					nxt_state = ST_DONE;
				end
			end
			ST_DONE: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_ff  <= ST_IDLE;
			busy_ff   <= 1'b0;
			result_ff <= RC_OK;
		end else begin
			state_ff  <= nxt_state;
			busy_ff   <= (nxt_state != ST_IDLE); // R15
			result_ff <= nxt_result;
		end
	end

	// Requests are edge-triggered, so a host holding the request high starts one command.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			req_prev_ff <= 1'b0;
		end else begin
			req_prev_ff <= i_req;
		end
	end

	// Argument fetch bookkeeping.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			fc_ff        <= FC_TRANSPARENT;
			zero_cnt_ff  <= 1'b0;
			remain_ff    <= CNT_ZERO;
			arg_ready_ff <= 1'b0;
		end else if (go_fetch) begin
			fc_ff        <= i_function_code;
			zero_cnt_ff  <= fc_filter && (i_entry_count == CNT_ZERO);
			remain_ff    <= load_remain;
			arg_ready_ff <= 1'b1;
		end else if (arg_take) begin
			remain_ff    <= remain_ff - CNT_ONE;
			arg_ready_ff <= !last_arg;
		end
	end

	// Transparent mode is one-way; only a reset brings the protocol back.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			transp_ff  <= 1'b0;
			prot_en_ff <= 1'b1;
		end else begin
			transp_ff  <= transp_ff || go_transp; // R2
			prot_en_ff <= prot_en_ff && !go_transp; // R2
		end
	end

	// Bus-off setting wins over its clear, so a controller still off stays halted.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			bus_off_ff <= 1'b0;
		end else begin
			bus_off_ff <= i_bus_off || (bus_off_ff && !go_clr_bo); // R14 R18
		end
	end

	// An out-of-range limit keeps the old value and completes with a bad-argument result.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			thr_ff <= THR_RESET;
		end else if (thr_wr) begin
			thr_ff <= i_arg_word[BUF_CW-1:0]; // R12
		end
	end

	// Presented frame survives a flush until the host acknowledges it.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			new_ff   <= 1'b0;
			frame_ff <= '0;
		end else if (pop) begin
			new_ff   <= 1'b1;
			frame_ff <= fifo_out;
		end else if (i_ack) begin
			new_ff   <= 1'b0; // R13
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			status_ff  <= '0;
			ext_err_ff <= 1'b0;
		end else begin
			status_ff  <= nxt_status;
			ext_err_ff <= i_diag_en && (nxt_status != '0); // R22
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rx_ready_ff <= 1'b0;
			listen_ff   <= 1'b0;
		end else begin
			rx_ready_ff <= fifo_in_ready && path_on;
			listen_ff   <= path_on; // R4
		end
	end

	// Ready to the controller lags a cycle; a frame offered to a full buffer is dropped.
	assign o_busy        = busy_ff;
	assign o_result_code = result_ff;
	assign o_arg_ready   = arg_ready_ff;
	assign o_rx_ready    = rx_ready_ff;
	assign o_new         = new_ff;
	assign o_frame       = frame_ff;
	assign o_ctrl_halt   = bus_off_ff;
	assign o_protocol_en = prot_en_ff;
	assign o_listen      = listen_ff;
	assign o_status      = status_ff;
	assign o_ext_error   = ext_err_ff;
endmodule

// file: src/tcc_pkg.sv
/*
 * Shared constants and carrier types for the transparent receive command and status block.
 * Assumes one 50 MHz clock and a synchronous, active-high reset for every user of the package.
 */
// Behaviour
// R1 - Function code picks one of five operations
// R2 - Code zero enters transparent mode until reset
// R3 - Other codes accepted only in transparent mode
// R4 - Empty acceptance filter means all traffic ignored
// R5 - Filter may be reprogrammed at any time
// R6 - Entry count used only by filter code
// R7 - Entry: bit 15 enable, bits 14-0 identifier
// R8 - Count zero, entry zero disables every identifier
// R9 - Count one, entry zero disables identifier zero
// R10 - Count one, entry FFFFh enables every identifier
// R11 - Many entries per command, commands apply cumulatively
// R12 - Threshold resets 255, settable 1-255, sets bit4
// R13 - Flush empties buffer, presented frame stays presented
// R14 - Bus-off halts controller until code five
// R15 - Busy until done, result valid until next request
// R16 - Host holds request high one scan cycle
// R17 - Status is 32 independent bits, zero means clear
// R18 - Bit 0 reports bus-off
// R19 - Bit 1 reports error counter past warning
// R20 - Bit 2 set at 255 frames, clears on read
// R21 - Bit 3 set at 128 frames held
// R22 - Diagnosis enabled: external error while status nonzero
// R23 - Buffer holds 255 frames until host reads them
// R24 - Unused status bits zero, reserved code errors
package tcc_pkg;

	// Command encoding and argument widths.
	localparam int FC_W   = 8;
	localparam int CNT_W  = 16;
	localparam int ARG_W  = 16;
	localparam int RES_W  = 16;

	localparam logic [FC_W-1:0] FC_TRANSPARENT = 8'h00;
	localparam logic [FC_W-1:0] FC_FILTER      = 8'h01;
	localparam logic [FC_W-1:0] FC_THRESHOLD   = 8'h02;
	localparam logic [FC_W-1:0] FC_FLUSH       = 8'h03;
	localparam logic [FC_W-1:0] FC_RESERVED    = 8'h04;
	localparam logic [FC_W-1:0] FC_CLR_BUS_OFF = 8'h05;

	// Result codes.
	localparam logic [RES_W-1:0] RC_OK          = 16'h0000;
	localparam logic [RES_W-1:0] RC_NOT_TRANSP  = 16'h0001;
	localparam logic [RES_W-1:0] RC_RESERVED    = 16'h0002;
	localparam logic [RES_W-1:0] RC_BAD_ARG     = 16'h0003;
	localparam logic [RES_W-1:0] RC_UNKNOWN_FC  = 16'h0004;

	// Filter entry layout.
	localparam int ENT_EN_BIT = 15;
	localparam int ENT_ID_HI  = 14;
	localparam int ID_W       = 11;
	localparam int N_ID       = 2048;
	localparam logic [ARG_W-1:0] ENT_ALL_ON  = 16'hFFFF;
	localparam logic [ARG_W-1:0] ENT_ALL_OFF = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ZERO    = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE     = 16'h0001;

	// Receive buffer.
	localparam int BUF_DEPTH = 255;
	localparam int BUF_CW    = 8;
	localparam logic [BUF_CW-1:0] BUF_FULL_CNT = 8'hFF;
	localparam logic [BUF_CW-1:0] BUF_HALF_CNT = 8'h80;
	localparam logic [BUF_CW-1:0] THR_RESET    = 8'hFF;
	localparam logic [BUF_CW-1:0] THR_MIN      = 8'h01;

	// Status bit positions.
	localparam int ST_W        = 32;
	localparam int ST_BUS_OFF  = 0;
	localparam int ST_ERR_PASS = 1;
	localparam int ST_FULL     = 2;
	localparam int ST_HALF     = 3;
	localparam int ST_THR_HIT  = 4;

	typedef struct packed {
		logic [ID_W-1:0] id;
		logic            rtr;
		logic [3:0]      dlc;
		logic [63:0]     data;
	} tcc_frame_t;

	localparam int FRAME_W = $bits(tcc_frame_t);

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FETCH = 2'b01,
		ST_DONE  = 2'b11
	} tcc_state_t;

endpackage

// file: verification/tcc_control_monitor.sv
/* Concurrent checks on the command and status ports of tcc_control.
 * Assumes one clock and a host that raises a request only while the block is idle. */
`timescale 1ns/1ps
module tcc_control_monitor (
	// Clock, reset and command.
	input wire logic                       i_clk,
	input wire logic                       i_rst,
	input wire logic                       i_req,
	input wire logic [tcc_pkg::FC_W-1:0]   i_function_code,
	input wire logic                       o_busy,
	input wire logic [tcc_pkg::RES_W-1:0]  o_result_code,
	input wire logic                       o_arg_ready,
	// Conditions and status.
	input wire logic                       i_bus_off,
	input wire logic                       i_ack,
	input wire logic                       o_new,
	input wire logic                       o_ctrl_halt,
	input wire logic                       o_protocol_en,
	input wire logic [tcc_pkg::ST_W-1:0]   o_status
);
	import tcc_pkg::*;
	logic req_q_ff;
	logic take;
	logic short_fc;
	// A level request only counts on its rising edge, so the previous level is kept.
	assign take = i_req && !req_q_ff && !o_busy;
	assign short_fc = i_function_code inside {FC_TRANSPARENT, FC_FLUSH, FC_RESERVED, FC_CLR_BUS_OFF};
	always_ff @(posedge i_clk) begin
		req_q_ff <= i_rst ? 1'b0 : i_req;
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	a_busy_one: assert property (take && short_fc |=> o_busy ##1 !o_busy)
		else $error("busy not high for one cycle");
	a_not_transp: assert property (take && i_function_code != FC_TRANSPARENT && o_protocol_en
		|=> o_result_code == RC_NOT_TRANSP) else $error("command taken outside transparent mode");
	a_transp_stays: assert property (!o_protocol_en |=> !o_protocol_en)
		else $error("transparent mode left without reset");
	a_halt_set: assert property (i_bus_off |-> ##[1:2] o_ctrl_halt)
		else $error("bus-off did not halt the controller");
	a_halt_hold: assert property (o_ctrl_halt && !o_busy && !i_req |=> o_ctrl_halt)
		else $error("halt cleared without a command");
	a_status_spare: assert property (o_status[ST_W-1:ST_THR_HIT+1] == '0)
		else $error("unassigned status bit set");
	a_full_half: assert property (o_status[ST_FULL] |-> o_status[ST_HALF])
		else $error("full without half full");
	a_new_stays: assert property (o_new && !i_ack |=> o_new)
		else $error("presented frame lost before ack");
	a_arg_wanted: assert property (take && !o_protocol_en &&
		(i_function_code == FC_FILTER || i_function_code == FC_THRESHOLD) |=> o_arg_ready)
		else $error("argument words not requested");
	c_thr: cover property (o_status[ST_THR_HIT]);
	c_filter: cover property (take && i_function_code == FC_FILTER);
	c_full: cover property (o_status[ST_FULL]);
	c_halt: cover property (o_ctrl_halt && o_status[ST_BUS_OFF]);
endmodule
bind tcc_control tcc_control_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
	.i_function_code(i_function_code), .o_busy(o_busy), .o_result_code(o_result_code),
	.o_arg_ready(o_arg_ready),
	.i_bus_off(i_bus_off), .i_ack(i_ack), .o_new(o_new), .o_ctrl_halt(o_ctrl_halt),
	.o_protocol_en(o_protocol_en), .o_status(o_status));

// file: verification/tcc_host_model.sv
/* Host model: issues one command at a time and streams one argument word with it.
 * Assumes the request, busy and result handshake of tcc_control on a shared clock. */
`timescale 1ns/1ps
module tcc_host_model (
	// Clock and answer.
	input  wire logic                      i_clk,
	input  wire logic                      i_busy,
	input  wire logic [tcc_pkg::RES_W-1:0] i_result_code,
	// Request.
	output logic                           o_req,
	output logic [tcc_pkg::FC_W-1:0]       o_function_code,
	output logic [tcc_pkg::CNT_W-1:0]      o_entry_count,
	output logic                           o_arg_valid,
	output logic [tcc_pkg::ARG_W-1:0]      o_arg_word
);
	import tcc_pkg::*;
	initial begin
		o_req = 1'b0;
		o_function_code = 8'h00;
		o_entry_count = 16'h0000;
		o_arg_valid = 1'b0;
		o_arg_word = 16'h0000;
	end
	task automatic run(input logic [FC_W-1:0] f, input logic [CNT_W-1:0] c,
			input logic [ARG_W-1:0] w, output logic [RES_W-1:0] r, output logic tmo);
		int k;
		k = 0;
		@(negedge i_clk);
		o_function_code = f;
		o_entry_count = c;
		o_arg_word = w;
		o_arg_valid = 1'b1;
		o_req = 1'b1;
		@(negedge i_clk);
		o_req = 1'b0;
		while (i_busy === 1'b1 && k < 40) begin
			@(negedge i_clk);
			k++;
		end
		o_arg_valid = 1'b0;
		// A released word changes, so a late read cannot pass by luck.
		o_arg_word = ~w;
		r = i_result_code;
		tmo = (k >= 40);
	endtask
endmodule

// file: verification/tb_tcc_control.sv
/* Self-checking bench for tcc_control: commands through the host model, frames driven here.
 * Assumes the hand-over timing of the block; inputs change on the falling edge. */
`timescale 1ns/1ps
module tb_tcc_control;
	import tcc_pkg::*;
	logic             i_clk = 1'b0;
	logic             i_rst = 1'b1;
	logic             req;
	logic             busy;
	logic             arg_valid;
	logic [FC_W-1:0]  fc;
	logic [CNT_W-1:0] cnt;
	logic [ARG_W-1:0] arg_word;
	logic [RES_W-1:0] res;
	logic             i_rx_valid = 1'b0;
	tcc_frame_t       i_rx_frame = '0;
	tcc_frame_t       o_frame;
	logic             o_new;
	logic             i_ack = 1'b0;
	logic             i_bus_off = 1'b0;
	logic             i_err_warn = 1'b0;
	logic             i_diag_en = 1'b0;
	logic             o_ctrl_halt;
	logic             o_protocol_en;
	logic             o_ext_error;
	logic             listen;
	logic             rx_ready;
	logic             arg_ready;
	logic [ST_W-1:0]  o_status;
	int               n_mismatch = 0;
	int               check_count = 0;
	int               cyc = 0;
	always #10 i_clk = ~i_clk;
	tcc_host_model h (.i_clk(i_clk), .i_busy(busy), .i_result_code(res), .o_req(req),
		.o_function_code(fc), .o_entry_count(cnt), .o_arg_valid(arg_valid), .o_arg_word(arg_word));
	tcc_control dut (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_function_code(fc),
		.i_entry_count(cnt), .o_busy(busy), .o_result_code(res), .i_arg_valid(arg_valid),
		.i_arg_word(arg_word), .o_arg_ready(arg_ready), .i_rx_valid(i_rx_valid),
		.i_rx_frame(i_rx_frame), .o_rx_ready(rx_ready), .o_new(o_new), .o_frame(o_frame),
		.i_ack(i_ack), .i_bus_off(i_bus_off), .i_err_warn(i_err_warn),
		.o_ctrl_halt(o_ctrl_halt), .o_protocol_en(o_protocol_en), .o_listen(listen),
		.i_diag_en(i_diag_en), .o_status(o_status), .o_ext_error(o_ext_error));
	task automatic report_and_stop();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cmd(input logic [FC_W-1:0] f, input logic [CNT_W-1:0] c,
			input logic [ARG_W-1:0] w, input logic [RES_W-1:0] exp);
		logic [RES_W-1:0] r;
		logic             tmo;
		h.run(f, c, w, r, tmo);
		chk("busy wait", 32'h0, {31'h0, tmo});
		chk("result_code", {16'h0, exp}, {16'h0, r});
	endtask
	task automatic push(input logic [ID_W-1:0] id, input int n);
		@(negedge i_clk);
		i_rx_frame.id = id;
		i_rx_valid = 1'b1;
		repeat (n) @(negedge i_clk);
		i_rx_valid = 1'b0;
		i_rx_frame = ~i_rx_frame;
		repeat (4) @(negedge i_clk);
	endtask
	task automatic ack();
		@(negedge i_clk);
		i_ack = 1'b1;
		@(negedge i_clk);
		i_ack = 1'b0;
		repeat (3) @(negedge i_clk);
	endtask
	// The whole sequence needs well under two thousand cycles.
	always @(posedge i_clk) begin
		cyc++;
		if (cyc >= 5000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	initial begin
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		i_rst = 1'b0;
		@(negedge i_clk);
		chk("status", 32'h0, o_status);
		chk("protocol_en", 32'h1, o_protocol_en);
		cmd(FC_FILTER, CNT_ONE, 16'h8005, RC_NOT_TRANSP);
		cmd(FC_TRANSPARENT, CNT_ZERO, 16'h0000, RC_OK);
		chk("protocol_en", 32'h0, o_protocol_en);
		cmd(FC_RESERVED, CNT_ZERO, 16'h0000, RC_RESERVED);
		push(11'h005, 1);
		chk("new", 32'h0, o_new);
		chk("listen", 32'h0, listen);
		cmd(FC_FILTER, CNT_ONE, 16'h8005, RC_OK);
		chk("listen", 32'h1, listen);
		chk("rx_ready", 32'h1, rx_ready);
		push(11'h006, 1);
		chk("new", 32'h0, o_new);
		push(11'h005, 1);
		chk("frame id", 32'h5, o_frame.id);
		cmd(FC_THRESHOLD, CNT_ZERO, 16'h0000, RC_BAD_ARG);
		cmd(FC_THRESHOLD, 16'h0009, 16'h0002, RC_OK);
		chk("arg_ready", 32'h0, arg_ready);
		push(11'h005, 2);
		chk("status", 32'h10, o_status);
		cmd(FC_FLUSH, CNT_ZERO, 16'h0000, RC_OK);
		repeat (2) @(negedge i_clk);
		chk("status", 32'h0, o_status);
		chk("new", 32'h1, o_new);
		cmd(FC_FILTER, CNT_ONE, ENT_ALL_ON, RC_OK);
		ack();
		chk("new", 32'h0, o_new);
		push(11'h123, 256);
		chk("status", 32'h1C, o_status);
		chk("rx_ready", 32'h0, rx_ready);
		ack();
		chk("status", 32'h18, o_status);
		cmd(FC_FILTER, 16'h0002, 16'h8000, RC_OK);
		cmd(FC_FILTER, CNT_ONE, ENT_ALL_OFF, RC_OK);
		chk("listen", 32'h1, listen);
		cmd(FC_FILTER, CNT_ZERO, ENT_ALL_OFF, RC_OK);
		chk("listen", 32'h0, listen);
		cmd(FC_FLUSH, CNT_ZERO, 16'h0000, RC_OK);
		ack();
		push(11'h123, 1);
		chk("new", 32'h0, o_new);
		i_diag_en = 1'b1;
		i_err_warn = 1'b1;
		i_bus_off = 1'b1;
		repeat (4) @(negedge i_clk);
		chk("status", 32'h3, o_status);
		chk("ext_error", 32'h1, o_ext_error);
		i_bus_off = 1'b0;
		i_err_warn = 1'b0;
		repeat (4) @(negedge i_clk);
		chk("halt", 32'h1, o_ctrl_halt);
		cmd(FC_CLR_BUS_OFF, CNT_ZERO, 16'h0000, RC_OK);
		repeat (3) @(negedge i_clk);
		chk("halt", 32'h0, o_ctrl_halt);
		chk("status", 32'h0, o_status);
		chk("ext_error", 32'h0, o_ext_error);
		report_and_stop();
	end
endmodule
